// ==== shared/tcu_defines.svh ====
// constants for the transmit credit user port
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH

// ==========================================================
// credit bus layout
`define TCU_HDR_W 9
`define TCU_DATA_W 13
`define TCU_NCLASS 3
`define TCU_CLS_POSTED 2'h0
`define TCU_CLS_NONPOSTED 2'h1
`define TCU_CLS_CPL 2'h2

// ==========================================================
// header fields of the first 64-bit word
`define TCU_HAS_DATA_BIT 62
`define TCU_TYPE_HI 60
`define TCU_TYPE_LO 56
`define TCU_LEN_HI 41
`define TCU_LEN_LO 32
`define TCU_TYPE_MEM 4'h0
`define TCU_TYPE_CPL 4'h5
`define TCU_TYPE_MSG 2'h2
`define TCU_LEN_MAX_CREDITS 9'h100

// ==========================================================
// datapath
`define TCU_WORD_W 64
`define TCU_BYTES 8

`endif

// ==== shared/tcu_pkg.sv ====
// types shared by the transmit credit user port
package tcu_pkg;
    typedef enum logic {
        TCU_IDLE,
        TCU_XFER
    } tcu_state_type;
endpackage

// ==== verilog/tcu_credit_ctr.sv ====
// one credit counter with infinite flag in the top bit
`timescale 1ns/1ns
`include "tcu_defines.svh"
module tcu_credit_ctr
    import tcu_pkg::*;
#(
    parameter int W = `TCU_HDR_W
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // flow-control update
    input wire logic i_upd,
    input wire logic i_upd_inf,
    input wire logic [W-2:0] i_upd_inc,
    // consumption on a sent tlp
    input wire logic i_use,
    input wire logic [W-2:0] i_use_amt,
    // credit available
    output logic [W-1:0] o_avail
);

    logic [W-1:0] next_avail;

    // ==========================================================
    // counter
    always_comb begin
        logic [W-1:0] sum;
        sum = {1'b0, o_avail[W-2:0]} + {1'b0, i_upd_inc};
        next_avail = o_avail;
        // once infinite, later updates leave the ignored count alone
        if (i_upd && !o_avail[W-1]) begin
            if (i_upd_inf) begin
                next_avail[W-1] = 1'b1;
            end else if (sum[W-1]) begin
                next_avail[W-2:0] = '1;
            end else begin
                next_avail[W-2:0] = sum[W-2:0];
            end
        end
        // infinite credit is never spent
        if (i_use && !next_avail[W-1]) begin
            if (next_avail[W-2:0] > i_use_amt) begin
                next_avail[W-2:0] = next_avail[W-2:0] - i_use_amt;
            end else begin
                next_avail[W-2:0] = '0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_avail <= '0;
        end else begin
            o_avail <= next_avail;
        end
    end

    // ==========================================================
    // checks
    a_rise_needs_update: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_upd |=> o_avail[W-2:0] <= $past(o_avail[W-2:0]))
        else $error("credit rose without an update");
    a_inf_sticky: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_avail[W-1] |=> o_avail[W-1] && $stable(o_avail[W-2:0]))
        else $error("infinite credit count changed");

endmodule // tcu_credit_ctr

// ==== verilog/tcu_tx_port.sv ====
// transmit tlp user port with credit accounting and receive byte order
// Functional notes
// - cancel ends tlp; no last with it
// - upper-half flag marks only [63:32] valid
// - downshift clock enable; advance only when high
// - three 9-bit header credit buses
// - header bit 8 means infinite credits
// - three 13-bit data credit buses
// - data bit 12 means infinite credits
// - credits rise only on flow-control update
// - posted send pulses posted recheck
// - completion send pulses completion recheck
// - receive bytes most significant first
// - request may stay high; ready drops between
// - receive first and last word marks
// - asynchronous active-low reset
`timescale 1ns/1ns
`include "tcu_defines.svh"
module tcu_tx_port
    import tcu_pkg::*;
#(
    parameter int NATIVE_LANES = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // user transmit side
    input wire logic i_tx_send_request,
    input wire logic i_tx_tlp_first,
    input wire logic i_tx_tlp_last,
    input wire logic i_tx_tlp_cancel,
    input wire logic i_tx_upper_half_only,
    input wire logic [`TCU_WORD_W-1:0] i_tx_word_bus,
    output logic o_tx_accept_ready,
    output logic o_tx_clk_en,
    // credit buses
    output logic [`TCU_HDR_W-1:0] o_posted_hdr_credit_avail,
    output logic [`TCU_HDR_W-1:0] o_nonposted_hdr_credit_avail,
    output logic [`TCU_HDR_W-1:0] o_cpl_hdr_credit_avail,
    output logic [`TCU_DATA_W-1:0] o_posted_data_credit_avail,
    output logic [`TCU_DATA_W-1:0] o_nonposted_data_credit_avail,
    output logic [`TCU_DATA_W-1:0] o_cpl_data_credit_avail,
    output logic o_posted_credit_recheck,
    output logic o_cpl_credit_recheck,
    // link side: lane width and flow-control updates
    input wire logic [2:0] i_trained_lanes,
    input wire logic i_fc_update,
    input wire logic [1:0] i_fc_class,
    input wire logic i_fc_hdr_inf,
    input wire logic [`TCU_HDR_W-2:0] i_fc_hdr_inc,
    input wire logic i_fc_data_inf,
    input wire logic [`TCU_DATA_W-2:0] i_fc_data_inc,
    // link side: outgoing words
    output logic o_link_valid,
    output logic o_link_first,
    output logic o_link_last,
    output logic o_link_cancel,
    output logic o_link_upper_half,
    output logic [`TCU_WORD_W-1:0] o_link_word,
    // link side: incoming words, byte 0 in the low lane
    input wire logic i_link_rx_valid,
    input wire logic i_link_rx_first,
    input wire logic i_link_rx_last,
    input wire logic [`TCU_WORD_W-1:0] i_link_rx_word,
    // user receive side
    output logic o_rx_valid,
    output logic o_rx_tlp_first,
    output logic o_rx_tlp_last,
    output logic [`TCU_WORD_W-1:0] o_rx_word_bus
);

    // ==========================================================
    // helper functions
    function automatic logic [1:0] tlp_class(input logic [`TCU_WORD_W-1:0] w);
        logic [4:0] t;
        t = w[`TCU_TYPE_HI:`TCU_TYPE_LO];
        if ((w[`TCU_HAS_DATA_BIT] && t[4:1] == `TCU_TYPE_MEM) || t[4:3] == `TCU_TYPE_MSG) begin
            return `TCU_CLS_POSTED;
        end else if (t[4:1] == `TCU_TYPE_CPL) begin
            return `TCU_CLS_CPL;
        end else begin
            return `TCU_CLS_NONPOSTED;
        end
    endfunction

    // data credits are 4 dwords each; zero length means 1024 dwords
    function automatic logic [`TCU_DATA_W-2:0] data_cost(input logic [`TCU_WORD_W-1:0] w);
        logic [10:0] len;
        len = {1'b0, w[`TCU_LEN_HI:`TCU_LEN_LO]};
        if (!w[`TCU_HAS_DATA_BIT]) begin
            return '0;
        end else if (len == 11'h000) begin
            return {3'h0, `TCU_LEN_MAX_CREDITS};
        end else begin
            return {3'h0, 9'((len + 11'h003) >> 2)};
        end
    endfunction

    function automatic logic [`TCU_WORD_W-1:0] msb_first(input logic [`TCU_WORD_W-1:0] w);
        logic [`TCU_WORD_W-1:0] r;
        r = '0;
        for (int i = 0; i < `TCU_BYTES; i++) begin
            r[`TCU_WORD_W-1-8*i -: 8] = w[8*i +: 8];
        end
        return r;
    endfunction

    // ==========================================================
    // downshift clock enable
    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;
    logic next_clk_en;

    always_comb begin
        logic [2:0] ratio;
        ratio = 3'h1;
        if (int'(i_trained_lanes) >= NATIVE_LANES) begin
            ratio = 3'h1;
        end else if (i_trained_lanes == 3'h2) begin
            ratio = 3'(NATIVE_LANES / 2);
        end else begin
            ratio = 3'(NATIVE_LANES);
        end
        next_clk_en = (div_cnt == 3'h0);
        next_div_cnt = (div_cnt + 3'h1 >= ratio) ? 3'h0 : div_cnt + 3'h1;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_cnt <= 3'h0;
            o_tx_clk_en <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            o_tx_clk_en <= next_clk_en;
        end
    end

    // ==========================================================
    // transmit handshake and word forwarding
    tcu_state_type state;
    tcu_state_type next_state;
    logic in_tlp;
    logic next_in_tlp;
    logic [1:0] cur_class;
    logic [1:0] next_cur_class;
    logic [`TCU_DATA_W-2:0] cur_cost;
    logic [`TCU_DATA_W-2:0] next_cur_cost;
    logic next_ready;
    logic take;
    logic commit;
    logic [1:0] commit_class;
    logic [`TCU_DATA_W-2:0] commit_cost;

    always_comb begin
        take = (state == TCU_XFER) && o_tx_clk_en && (i_tx_tlp_first || in_tlp);
        next_state = state;
        next_in_tlp = in_tlp;
        next_cur_class = cur_class;
        next_cur_cost = cur_cost;
        next_ready = 1'b0;
        commit = 1'b0;
        commit_class = cur_class;
        commit_cost = cur_cost;
        case (state)
            TCU_IDLE: begin
                // one ready pulse per tlp, so ready drops between tlps
                if (i_tx_send_request && o_tx_clk_en) begin
                    next_ready = 1'b1;
                    next_state = TCU_XFER;
                end
            end
            TCU_XFER: begin
                if (take) begin
                    if (i_tx_tlp_first) begin
                        commit_class = tlp_class(i_tx_word_bus);
                        commit_cost = data_cost(i_tx_word_bus);
                        next_cur_class = commit_class;
                        next_cur_cost = commit_cost;
                        next_in_tlp = 1'b1;
                    end
                    if (i_tx_tlp_cancel) begin
                        next_in_tlp = 1'b0;
                        next_state = TCU_IDLE;
                    end else if (i_tx_tlp_last) begin
                        commit = 1'b1;
                        next_in_tlp = 1'b0;
                        next_state = TCU_IDLE;
                    end
                end
            end
            default: begin
                next_state = TCU_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= TCU_IDLE;
            in_tlp <= 1'b0;
            cur_class <= `TCU_CLS_POSTED;
            cur_cost <= '0;
            o_tx_accept_ready <= 1'b0;
            o_link_valid <= 1'b0;
            o_link_first <= 1'b0;
            o_link_last <= 1'b0;
            o_link_cancel <= 1'b0;
            o_link_upper_half <= 1'b0;
            o_link_word <= '0;
            o_posted_credit_recheck <= 1'b0;
            o_cpl_credit_recheck <= 1'b0;
        end else begin
            state <= next_state;
            in_tlp <= next_in_tlp;
            cur_class <= next_cur_class;
            cur_cost <= next_cur_cost;
            o_tx_accept_ready <= next_ready;
            o_link_valid <= take;
            o_link_first <= take && i_tx_tlp_first;
            o_link_last <= take && i_tx_tlp_last && !i_tx_tlp_cancel;
            o_link_cancel <= take && i_tx_tlp_cancel;
            o_link_upper_half <= take && i_tx_upper_half_only;
            o_link_word <= take ? i_tx_word_bus : o_link_word;
            o_posted_credit_recheck <= commit && commit_class == `TCU_CLS_POSTED;
            o_cpl_credit_recheck <= commit && commit_class == `TCU_CLS_CPL;
        end
    end

    // ==========================================================
    // credit counters, one header and one data per class
    logic [`TCU_HDR_W-1:0] hdr_avail [`TCU_NCLASS];
    logic [`TCU_DATA_W-1:0] data_avail [`TCU_NCLASS];

    for (genvar c = 0; c < `TCU_NCLASS; c++) begin : g_cls
        logic upd;
        logic use_c;
        assign upd = i_fc_update && i_fc_class == 2'(c);
        assign use_c = commit && commit_class == 2'(c);
        tcu_credit_ctr #(.W(`TCU_HDR_W)) u_hdr (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_upd(upd),
            .i_upd_inf(i_fc_hdr_inf),
            .i_upd_inc(i_fc_hdr_inc),
            .i_use(use_c),
            .i_use_amt(8'h01),
            .o_avail(hdr_avail[c])
        );
        tcu_credit_ctr #(.W(`TCU_DATA_W)) u_data (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_upd(upd),
            .i_upd_inf(i_fc_data_inf),
            .i_upd_inc(i_fc_data_inc),
            .i_use(use_c),
            .i_use_amt(commit_cost),
            .o_avail(data_avail[c])
        );
    end

    assign o_posted_hdr_credit_avail = hdr_avail[`TCU_CLS_POSTED];
    assign o_nonposted_hdr_credit_avail = hdr_avail[`TCU_CLS_NONPOSTED];
    assign o_cpl_hdr_credit_avail = hdr_avail[`TCU_CLS_CPL];
    assign o_posted_data_credit_avail = data_avail[`TCU_CLS_POSTED];
    assign o_nonposted_data_credit_avail = data_avail[`TCU_CLS_NONPOSTED];
    assign o_cpl_data_credit_avail = data_avail[`TCU_CLS_CPL];

    // ==========================================================
    // receive path: reorder to most significant byte first
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_valid <= 1'b0;
            o_rx_tlp_first <= 1'b0;
            o_rx_tlp_last <= 1'b0;
            o_rx_word_bus <= '0;
        end else begin
            o_rx_valid <= i_link_rx_valid;
            o_rx_tlp_first <= i_link_rx_valid && i_link_rx_first;
            o_rx_tlp_last <= i_link_rx_valid && i_link_rx_last;
            o_rx_word_bus <= i_link_rx_valid ? msb_first(i_link_rx_word) : o_rx_word_bus;
        end
    end

    // ==========================================================
    // checks
    sequence s_grant;
        o_tx_accept_ready ##1 !o_tx_accept_ready;
    endsequence
    sequence s_posted_done;
        take && i_tx_tlp_last && !i_tx_tlp_cancel && in_tlp && cur_class == `TCU_CLS_POSTED;
    endsequence

    a_ready_gap: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_tx_accept_ready |-> s_grant)
        else $error("ready held for more than one cycle");
    a_word_on_en: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_link_valid |-> $past(o_tx_clk_en))
        else $error("word taken without clock enable");
    a_full_width_en: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (int'(i_trained_lanes) >= NATIVE_LANES)[*3] |-> o_tx_clk_en)
        else $error("enable throttled at full width");
    a_posted_recheck: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_posted_done |=> o_posted_credit_recheck && !o_cpl_credit_recheck)
        else $error("posted send without recheck pulse");
    a_cpl_recheck_cause: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_cpl_credit_recheck |-> $past(commit) && $past(commit_class) == `TCU_CLS_CPL)
        else $error("completion recheck without completion send");
    a_cancel_no_last: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_link_cancel |-> !o_link_last ##1 !o_posted_credit_recheck && !o_cpl_credit_recheck)
        else $error("cancelled tlp ended or charged");
    a_rx_order: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_link_rx_valid |=> o_rx_word_bus[63:56] == $past(i_link_rx_word[7:0])
            && o_rx_word_bus[39:32] == $past(i_link_rx_word[31:24]))
        else $error("receive byte order wrong");
    a_rx_marks: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_link_rx_valid && i_link_rx_first) |=> o_rx_tlp_first && o_rx_valid)
        else $error("receive start mark lost");
    a_half_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_link_upper_half |-> o_link_valid && $past(i_tx_upper_half_only))
        else $error("half-word flag without its word");

endmodule // tcu_tx_port

// ==== verif/tcu_user_model.sv ====
// user application model driving the transmit side of the tlp port
`timescale 1ns/1ns
module tcu_user_model (
    // clock
    input wire logic i_clk,
    // device answers
    input wire logic i_tx_accept_ready,
    input wire logic i_tx_clk_en,
    // user transmit drive
    output logic o_tx_send_request,
    output logic o_tx_tlp_first,
    output logic o_tx_tlp_last,
    output logic o_tx_tlp_cancel,
    output logic o_tx_upper_half_only,
    output logic [63:0] o_tx_word_bus
);
    // ==========================================================
    // idle drive
    initial begin
        o_tx_send_request = 1'b0;
        o_tx_tlp_first = 1'b0;
        o_tx_tlp_last = 1'b0;
        o_tx_tlp_cancel = 1'b0;
        o_tx_upper_half_only = 1'b0;
        o_tx_word_bus = 64'h0;
    end

    // ==========================================================
    // one word, held until a cycle with the clock enable high takes it
    task automatic put(input logic [63:0] w, input logic f, input logic l, input logic c, input logic u);
        o_tx_tlp_first <= f;
        o_tx_tlp_last <= l;
        o_tx_tlp_cancel <= c;
        o_tx_upper_half_only <= u;
        o_tx_word_bus <= w;
        do @(posedge i_clk); while (i_tx_clk_en !== 1'b1);
    endtask

    // two-word tlp; cancel takes the place of last on the second word
    task automatic send(input logic [63:0] w0, input logic [63:0] w1, input logic cancel, input logic upper,
                        output logic ok);
        int n;
        n = 0;
        @(posedge i_clk);
        o_tx_send_request <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (i_tx_accept_ready !== 1'b1 && n < 64);
        ok = i_tx_accept_ready;
        // one tlp per request here, so no burst is left pending
        o_tx_send_request <= 1'b0;
        if (ok === 1'b1) begin
            put(w0, 1'b1, 1'b0, 1'b0, 1'b0);
            put(w1, 1'b0, !cancel, cancel, upper);
            o_tx_tlp_first <= 1'b0;
            o_tx_tlp_last <= 1'b0;
            o_tx_tlp_cancel <= 1'b0;
            o_tx_upper_half_only <= 1'b0;
            // released bus must not keep showing the last word
            o_tx_word_bus <= ~w1;
        end
    endtask
endmodule // tcu_user_model

// ==== verif/test_tlp_tx_credit_user_port.sv ====
// self-checking bench for the transmit tlp credit user port
`timescale 1ns/1ns
module test_tlp_tx_credit_user_port;
    logic i_clk, i_rstn, req, first, last, cancel, upper, ready, clk_en, prc, crc;
    logic [63:0] word, link_word, rx_in, rx_out;
    logic [8:0] ph, nph, ch;
    logic [12:0] pd, npd, cd;
    logic [2:0] i_trained_lanes;
    logic i_fc_update, i_fc_hdr_inf, i_fc_data_inf, l_val, l_first, l_last, l_cancel, l_upper;
    logic [1:0] i_fc_class;
    logic [7:0] i_fc_hdr_inc;
    logic [11:0] i_fc_data_inc;
    logic rx_v, rx_f, rx_l, o_v, o_f, o_l, ok;
    logic [63:0] n_prc, n_crc, n_lw, n_ll, n_lc, n_lu, n_en, first_w, re_pd;
    int n_errors = 0;
    int n_tests = 0;

    tcu_tx_port dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_tx_send_request(req), .i_tx_tlp_first(first),
        .i_tx_tlp_last(last), .i_tx_tlp_cancel(cancel), .i_tx_upper_half_only(upper), .i_tx_word_bus(word),
        .o_tx_accept_ready(ready), .o_tx_clk_en(clk_en), .o_posted_hdr_credit_avail(ph),
        .o_nonposted_hdr_credit_avail(nph), .o_cpl_hdr_credit_avail(ch), .o_posted_data_credit_avail(pd),
        .o_nonposted_data_credit_avail(npd), .o_cpl_data_credit_avail(cd), .o_posted_credit_recheck(prc),
        .o_cpl_credit_recheck(crc), .i_trained_lanes(i_trained_lanes), .i_fc_update(i_fc_update),
        .i_fc_class(i_fc_class), .i_fc_hdr_inf(i_fc_hdr_inf), .i_fc_hdr_inc(i_fc_hdr_inc),
        .i_fc_data_inf(i_fc_data_inf), .i_fc_data_inc(i_fc_data_inc), .o_link_valid(l_val),
        .o_link_first(l_first), .o_link_last(l_last), .o_link_cancel(l_cancel), .o_link_upper_half(l_upper),
        .o_link_word(link_word), .i_link_rx_valid(rx_v), .i_link_rx_first(rx_f), .i_link_rx_last(rx_l),
        .i_link_rx_word(rx_in), .o_rx_valid(o_v), .o_rx_tlp_first(o_f), .o_rx_tlp_last(o_l),
        .o_rx_word_bus(rx_out));

    tcu_user_model u_user (.i_clk(i_clk), .i_tx_accept_ready(ready), .i_tx_clk_en(clk_en),
        .o_tx_send_request(req), .o_tx_tlp_first(first), .o_tx_tlp_last(last), .o_tx_tlp_cancel(cancel),
        .o_tx_upper_half_only(upper), .o_tx_word_bus(word));

    // ==========================================================
    // clock and watchdog; the tests need well under 1000 cycles
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    initial begin
        repeat (4000) @(posedge i_clk);
        n_errors++;
        conclude;
    end

    // ==========================================================
    // monitor of pulses and forwarded words
    always @(posedge i_clk) begin
        if (prc === 1'b1) begin
            n_prc <= n_prc + 64'h1;
            // a waiting user re-reads the posted data credits on the pulse
            re_pd <= 64'(pd);
        end
        if (crc === 1'b1) n_crc <= n_crc + 64'h1;
        if (clk_en === 1'b1) n_en <= n_en + 64'h1;
        if (l_val === 1'b1) begin
            n_lw <= n_lw + 64'h1;
            if (l_first === 1'b1) first_w <= link_word;
            if (l_last === 1'b1) n_ll <= n_ll + 64'h1;
            if (l_cancel === 1'b1) n_lc <= n_lc + 64'h1;
            if (l_upper === 1'b1) n_lu <= n_lu + 64'h1;
        end
    end

    // ==========================================================
    // helpers
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic clr;
        @(negedge i_clk);
        {n_prc, n_crc, n_lw, n_ll, n_lc, n_lu, n_en, first_w} = '0;
    endtask

    task automatic cred(input logic [8:0] eph, input logic [12:0] epd, input logic [8:0] ech,
                        input logic [12:0] ecd);
        check("posted hdr", 64'(ph), 64'(eph));
        check("posted data", 64'(pd), 64'(epd));
        check("cpl hdr", 64'(ch), 64'(ech));
        check("cpl data", 64'(cd), 64'(ecd));
    endtask

    task automatic fc(input logic [1:0] c, input logic hi, input logic [7:0] h, input logic di,
                      input logic [11:0] d);
        @(posedge i_clk);
        i_fc_update <= 1'b1;
        i_fc_class <= c;
        i_fc_hdr_inf <= hi;
        i_fc_hdr_inc <= h;
        i_fc_data_inf <= di;
        i_fc_data_inc <= d;
        @(posedge i_clk);
        i_fc_update <= 1'b0;
    endtask

    function automatic logic [63:0] hdr(input logic d, input logic [4:0] t, input logic [9:0] len);
        return {1'b0, d, 1'b0, t, 14'h0, len, 32'h0};
    endfunction

    // send one tlp and check the pulses and words it leaves behind
    task automatic tlp(input logic [63:0] h, input logic cx, input logic [63:0] ep, input logic [63:0] ec);
        clr;
        u_user.send(h, 64'hC3C3_0000_3C3C_0000, cx, 1'b1, ok);
        repeat (3) @(negedge i_clk);
        check("ready", 64'(ok), 64'h1);
        check("posted recheck", n_prc, ep);
        check("cpl recheck", n_crc, ec);
        check("link words", n_lw, 64'h2);
        check("first word", first_w, h);
        check("upper half", n_lu, 64'h1);
        check("link last", n_ll, 64'(!cx));
        check("link cancel", n_lc, 64'(cx));
    endtask

    // ==========================================================
    // scenarios
    task automatic t_credits;
        cred(9'h000, 13'h0000, 9'h000, 13'h0000);
        fc(2'h0, 1'b0, 8'h05, 1'b0, 12'h010);
        fc(2'h1, 1'b1, 8'h00, 1'b1, 12'h000);
        fc(2'h2, 1'b0, 8'h07, 1'b0, 12'h012);
        repeat (6) @(negedge i_clk);
        cred(9'h005, 13'h0010, 9'h007, 13'h0012);
        check("np hdr inf", 64'(nph[8]), 64'h1);
        check("np data inf", 64'(npd[12]), 64'h1);
        $display("test credits finished");
    endtask

    task automatic t_send;
        tlp(hdr(1'b1, 5'h00, 10'h004), 1'b0, 64'h1, 64'h0);
        cred(9'h004, 13'h000F, 9'h007, 13'h0012);
        check("recheck posted data", re_pd, 64'h000F);
        tlp(hdr(1'b1, 5'h0A, 10'h008), 1'b0, 64'h0, 64'h1);
        cred(9'h004, 13'h000F, 9'h006, 13'h0010);
        tlp(hdr(1'b1, 5'h00, 10'h004), 1'b1, 64'h0, 64'h0);
        cred(9'h004, 13'h000F, 9'h006, 13'h0010);
        tlp(hdr(1'b0, 5'h00, 10'h001), 1'b0, 64'h0, 64'h0);
        check("np hdr inf kept", 64'(nph[8]), 64'h1);
        $display("test send finished");
    endtask

    task automatic t_rx;
        @(posedge i_clk);
        rx_v <= 1'b1;
        rx_f <= 1'b1;
        rx_l <= 1'b1;
        rx_in <= 64'h0706050403020100;
        @(posedge i_clk);
        rx_v <= 1'b0;
        rx_f <= 1'b0;
        rx_l <= 1'b0;
        rx_in <= 64'hF8F9FAFBFCFDFEFF;
        @(negedge i_clk);
        check("rx word", rx_out, 64'h0001020304050607);
        check("rx marks", {61'h0, o_v, o_f, o_l}, 64'h7);
        @(negedge i_clk);
        check("rx marks after", {61'h0, o_v, o_f, o_l}, 64'h0);
        $display("test receive finished");
    endtask

    task automatic t_downshift;
        for (int k = 0; k < 3; k++) begin
            @(posedge i_clk);
            i_trained_lanes <= 3'h4 >> k;
            repeat (8) @(posedge i_clk);
            clr;
            repeat (16) @(posedge i_clk);
            // let the monitor book the last edge before reading the count
            @(negedge i_clk);
            check("clk_en count", n_en, 64'h10 >> k);
        end
        tlp(hdr(1'b1, 5'h00, 10'h004), 1'b0, 64'h1, 64'h0);
        cred(9'h003, 13'h000E, 9'h006, 13'h0010);
        $display("test downshift finished");
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        i_rstn = 1'b0;
        i_trained_lanes = 3'h4;
        {i_fc_update, i_fc_class, i_fc_hdr_inf, i_fc_hdr_inc, i_fc_data_inf, i_fc_data_inc} = '0;
        {rx_v, rx_f, rx_l, rx_in} = '0;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(negedge i_clk);
        t_credits;
        t_send;
        t_rx;
        t_downshift;
        conclude;
    end
endmodule // test_tlp_tx_credit_user_port
